// ==== hw/hsb_bus_buffer.sv ====
// Operation
// - stay locked out until supply is good
// - precharge all lines during lockout
// - after lockout wait backplane stop or idle
// - then require both card lines high
// - connect only when all conditions hold together
// - any data low pulls both sides low
// - pairs rise when the followed side releases; a low still held on the other side is followed again after the guard
// - ready low on inhibit or incomplete start-up
// - ready high when connected and not inhibited
// - inhibit disconnects at once, ready low
// - after inhibit, requalify before reconnecting
// - release ready pull-down on reconnection
`timescale 1ns/100ps
`default_nettype none
module hsb_bus_buffer #(
  parameter int IDLE_CYCLES = hsb_pkg::BUS_IDLE_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic supply_good,
  input wire logic connect_inhibit,
  input wire logic backplane_data_line_in,
  output logic backplane_data_line_out,
  output logic backplane_data_line_oe,
  input wire logic backplane_clock_line_in,
  output logic backplane_clock_line_out,
  output logic backplane_clock_line_oe,
  input wire logic card_data_line_in,
  output logic card_data_line_out,
  output logic card_data_line_oe,
  input wire logic card_clock_line_in,
  output logic card_clock_line_out,
  output logic card_clock_line_oe,
  output logic ready_out,
  output logic ready_oe,
  output logic precharge_en
);
  localparam int IW = hsb_pkg::IN_WIDTH;
  localparam int ICW = $clog2(IDLE_CYCLES + 1);
  localparam logic [ICW-1:0] IDLE_LAST = ICW'(IDLE_CYCLES);
  localparam logic [2:0] GUARD_LAST = 3'(hsb_pkg::PAIR_GUARD_CYC);

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [IW-1:0] pin_raw; // all asynchronous pins
  logic [IW-1:0] sync1; // first stage, read only by sync2
  logic [IW-1:0] sync2; // usable levels
  logic [IW-1:0] sync_d; // one cycle older, for edge finding

  assign pin_raw = {connect_inhibit, supply_good, card_clock_line_in, card_data_line_in,
                    backplane_clock_line_in, backplane_data_line_in};

  // two flops per pin plus a history stage
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync1 <= hsb_pkg::SYNC_RST;
      sync2 <= hsb_pkg::SYNC_RST;
      sync_d <= hsb_pkg::SYNC_RST;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync_d <= sync2;
    end
  end

  // both lines of a side high
  function automatic logic both_high(input logic [IW-1:0] v, input int ofs);
    both_high = v[hsb_pkg::IN_BP_DATA + ofs] & v[hsb_pkg::IN_BP_CLK + ofs];
  endfunction

  logic supply_ok; // lockout released
  logic inhibit; // connect-inhibit asserted
  logic stop_det; // backplane stop condition
  logic bp_high; // backplane both high
  logic card_high; // card both high
  assign supply_ok = sync2[hsb_pkg::IN_SUPPLY];
  assign inhibit = sync2[hsb_pkg::IN_INHIBIT];
  assign bp_high = both_high(sync2, 0);
  assign card_high = both_high(sync2, hsb_pkg::CARD_OFS);
  // data rises while clock stays high
  assign stop_det = sync2[hsb_pkg::IN_BP_DATA] & ~sync_d[hsb_pkg::IN_BP_DATA]
                    & sync2[hsb_pkg::IN_BP_CLK] & sync_d[hsb_pkg::IN_BP_CLK];

  ////////////////////////////////////////////////////////////////////////
  // connection sequencer
  hsb_pkg::hsb_state_e state, next_state; // sequencer state
  logic [ICW-1:0] idle_cnt, next_idle_cnt; // backplane high time
  logic conn; // sides joined
  logic next_ready_oe; // ready pull-down
  logic next_precharge_en; // precharge request

  assign conn = (state == hsb_pkg::HSB_CONNECTED);

  // next state, idle counting and ready
  always_comb begin
    next_state = state;
    next_idle_cnt = idle_cnt;
    // idle timer runs in any state, saturates at the limit
    if (!bp_high) begin
      next_idle_cnt = '0;
    end else if (idle_cnt != IDLE_LAST) begin
      next_idle_cnt = idle_cnt + ICW'(1);
    end
    case (state)
      hsb_pkg::HSB_LOCKOUT: begin
        // lines ignored until supply is good
        if (supply_ok && !inhibit) begin
          next_state = hsb_pkg::HSB_WAIT_END;
        end
      end
      hsb_pkg::HSB_WAIT_END: begin
        // end of any transaction already running on the backplane
        if (stop_det || (idle_cnt == IDLE_LAST)) begin
          next_state = hsb_pkg::HSB_CHECK_CARD;
        end
      end
      hsb_pkg::HSB_CHECK_CARD: begin
        // a new backplane start voids the stop, so look again
        if (!bp_high) begin
          next_state = hsb_pkg::HSB_WAIT_END;
        end else if (card_high) begin
          next_state = hsb_pkg::HSB_CONNECTED;
        end
      end
      hsb_pkg::HSB_CONNECTED: begin
        next_state = state;
      end
      default: begin
        next_state = hsb_pkg::HSB_LOCKOUT;
      end
    endcase
    // inhibit breaks the link and restarts qualification
    if (inhibit && state != hsb_pkg::HSB_LOCKOUT) begin
      next_state = hsb_pkg::HSB_WAIT_END;
    end
    // supply loss wins over everything
    if (!supply_ok) begin
      next_state = hsb_pkg::HSB_LOCKOUT;
    end
    next_ready_oe = (next_state != hsb_pkg::HSB_CONNECTED);
    next_precharge_en = (next_state == hsb_pkg::HSB_LOCKOUT);
  end

  // sequencer registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= hsb_pkg::HSB_LOCKOUT;
      idle_cnt <= '0;
      ready_oe <= 1'b1;
      precharge_en <= 1'b1;
    end else begin
      state <= next_state;
      idle_cnt <= next_idle_cnt;
      ready_oe <= next_ready_oe;
      precharge_en <= next_precharge_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wired-and pairs: index 0 data, 1 clock
  // the side that went low first is followed; the other side is only
  // driven, never read, so our own pull-down cannot latch the pair.
  hsb_pkg::hsb_pair_e pst [2]; // pair state
  hsb_pkg::hsb_pair_e next_pst [2];
  logic [2:0] gcnt [2]; // guard counter
  logic [2:0] next_gcnt [2];
  logic [1:0] bp_oe; // drive backplane low
  logic [1:0] cd_oe; // drive card low
  logic [1:0] next_bp_oe;
  logic [1:0] next_cd_oe;

  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_pair
      logic bp_lvl; // backplane level of this pair
      logic cd_lvl; // card level of this pair
      assign bp_lvl = sync2[gp];
      assign cd_lvl = sync2[gp + hsb_pkg::CARD_OFS];

      // pair next state
      always_comb begin
        next_pst[gp] = pst[gp];
        next_gcnt[gp] = gcnt[gp];
        case (pst[gp])
          hsb_pkg::HSB_PR_IDLE: begin
            // low on either side pulls the other
            if (!bp_lvl) begin
              next_pst[gp] = hsb_pkg::HSB_PR_BP_LOW;
            end else if (!cd_lvl) begin
              next_pst[gp] = hsb_pkg::HSB_PR_CD_LOW;
            end
          end
          hsb_pkg::HSB_PR_BP_LOW: begin
            if (bp_lvl) begin
              next_pst[gp] = hsb_pkg::HSB_PR_GUARD;
              next_gcnt[gp] = '0;
            end
          end
          hsb_pkg::HSB_PR_CD_LOW: begin
            if (cd_lvl) begin
              next_pst[gp] = hsb_pkg::HSB_PR_GUARD;
              next_gcnt[gp] = '0;
            end
          end
          hsb_pkg::HSB_PR_GUARD: begin
            // lets our released side rise before it is read again;
            // a low held there afterwards is a real driver and is followed
            if (gcnt[gp] == GUARD_LAST) begin
              next_pst[gp] = hsb_pkg::HSB_PR_IDLE;
            end else begin
              next_gcnt[gp] = gcnt[gp] + 3'h1;
            end
          end
          default: begin
            next_pst[gp] = hsb_pkg::HSB_PR_IDLE;
          end
        endcase
        // no joining unless connected next
        if (next_state != hsb_pkg::HSB_CONNECTED) begin
          next_pst[gp] = hsb_pkg::HSB_PR_IDLE;
          next_gcnt[gp] = '0;
        end
        next_cd_oe[gp] = (next_pst[gp] == hsb_pkg::HSB_PR_BP_LOW);
        next_bp_oe[gp] = (next_pst[gp] == hsb_pkg::HSB_PR_CD_LOW);
      end

      // pair registers
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          pst[gp] <= hsb_pkg::HSB_PR_IDLE;
          gcnt[gp] <= '0;
          bp_oe[gp] <= 1'b0;
          cd_oe[gp] <= 1'b0;
        end else begin
          pst[gp] <= next_pst[gp];
          gcnt[gp] <= next_gcnt[gp];
          bp_oe[gp] <= next_bp_oe[gp];
          cd_oe[gp] <= next_cd_oe[gp];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // pin drivers, open drain: only ever pull low
  assign backplane_data_line_out = 1'b0;
  assign backplane_clock_line_out = 1'b0;
  assign card_data_line_out = 1'b0;
  assign card_clock_line_out = 1'b0;
  assign ready_out = 1'b0;
  assign backplane_data_line_oe = bp_oe[0];
  assign backplane_clock_line_oe = bp_oe[1];
  assign card_data_line_oe = cd_oe[0];
  assign card_clock_line_oe = cd_oe[1];

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  lockout_hold_a: assert property (!supply_ok |=> state == hsb_pkg::HSB_LOCKOUT)
    else $error("left lockout without good supply");
  precharge_on_a: assert property (state == hsb_pkg::HSB_LOCKOUT
    |-> precharge_en && bp_oe == 2'b00 && cd_oe == 2'b00)
    else $error("precharge off or pins driven in lockout");
  stop_seen_a: assert property (state == hsb_pkg::HSB_WAIT_END && stop_det && supply_ok && !inhibit
    |=> state == hsb_pkg::HSB_CHECK_CARD)
    else $error("stop condition not taken");
  card_check_a: assert property (state == hsb_pkg::HSB_CHECK_CARD && !card_high |=> !conn)
    else $error("connected with a card line low");
  connect_gate_a: assert property ($rose(conn) |-> $past(card_high && bp_high && !inhibit))
    else $error("connected without all conditions");
  data_follow_a: assert property (conn && pst[0] == hsb_pkg::HSB_PR_IDLE && !sync2[0]
    |=> cd_oe[0] || !conn)
    else $error("backplane data low not passed to card");
  pair_release_a: assert property (cd_oe[1] && sync2[hsb_pkg::IN_BP_CLK] |=> !cd_oe[1])
    else $error("card clock held after backplane release");
  ready_low_a: assert property (inhibit |=> ready_oe && !conn ##1 ready_oe)
    else $error("ready not low under inhibit");
  ready_high_a: assert property (conn |-> !ready_oe)
    else $error("ready low while connected");
  inhibit_cut_a: assert property (conn && inhibit |=> !conn && bp_oe == 2'b00 && cd_oe == 2'b00)
    else $error("inhibit did not disconnect");
  requalify_a: assert property ($fell(inhibit) |-> !conn ##1 !conn)
    else $error("reconnected without qualification");
  ready_release_a: assert property ($rose(conn) |-> $past(ready_oe) && !ready_oe)
    else $error("ready pull-down not released at connect");
  idle_limit_a: assert property (state == hsb_pkg::HSB_WAIT_END && idle_cnt == IDLE_LAST && supply_ok
    && !inhibit |=> state == hsb_pkg::HSB_CHECK_CARD)
    else $error("bus idle not taken");
  supply_loss_a: assert property (conn && !supply_ok |=> state == hsb_pkg::HSB_LOCKOUT && ready_oe)
    else $error("supply loss did not lock out");

  conn_by_stop_c: cover property (state == hsb_pkg::HSB_WAIT_END && stop_det ##[1:20] conn);
  conn_by_idle_c: cover property (idle_cnt == IDLE_LAST ##[1:20] conn);
  inhibit_drop_c: cover property (conn ##1 !conn && inhibit);
  pair_drive_c: cover property (cd_oe[0] ##[1:50] bp_oe[0]);
endmodule
`default_nettype wire

// ==== hw/hsb_pkg.sv ====
package hsb_pkg;
  // clock of the control logic
  localparam int CLK_PERIOD_NS = 10;
  // backplane both-high time that counts as bus idle
  localparam int BUS_IDLE_TIME_NS = 95000;
  localparam int BUS_IDLE_CYC = (BUS_IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // quiet time after a pair releases, covers sync delay and rise time
  localparam int PAIR_GUARD_TIME_NS = 40;
  localparam int PAIR_GUARD_CYC = (PAIR_GUARD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // synchronised input vector positions
  localparam int IN_BP_DATA = 0;
  localparam int IN_BP_CLK = 1;
  localparam int IN_CD_DATA = 2;
  localparam int IN_CD_CLK = 3;
  localparam int IN_SUPPLY = 4;
  localparam int IN_INHIBIT = 5;
  localparam int IN_WIDTH = 6;
  // card-side offset of a pair's input within the vector
  localparam int CARD_OFS = 2;
  // reset values of the synchronisers: lines high, supply low, inhibit high
  localparam logic [IN_WIDTH-1:0] SYNC_RST = 6'h2f;

  // connection sequencer states
  typedef enum logic [1:0] {
    HSB_LOCKOUT = 2'b00,
    HSB_WAIT_END = 2'b01,
    HSB_CHECK_CARD = 2'b10,
    HSB_CONNECTED = 2'b11
  } hsb_state_e;

  // per-pair wired-and states
  typedef enum logic [1:0] {
    HSB_PR_IDLE = 2'b00,
    HSB_PR_BP_LOW = 2'b01,
    HSB_PR_CD_LOW = 2'b10,
    HSB_PR_GUARD = 2'b11
  } hsb_pair_e;
endpackage

// ==== test/hsb_bus_partner.sv ====
`timescale 1ns/100ps
`default_nettype none
// far side: a backplane master that clocks frames, plus open-drain
// drivers on all four wires; every wire has its own pull-up
module hsb_bus_partner (
  input wire logic frame_on,
  input wire logic [3:0] pull,
  input wire logic [3:0] dev_oe,
  output logic [3:0] lvl
);
  logic link_low; // backplane master holds its clock low
  ////////////////////////////////////////
  // link clock of 80 ns, only inside a frame; between frames it stays
  // released so the pull-up holds it high, as a real master would
  initial begin
    link_low = 1'b0;
    forever begin
      wait (frame_on);
      #3;
      while (frame_on) begin
        link_low = ~link_low;
        #40;
      end
      link_low = 1'b0;
    end
  end
  // wired-and: any driver low wins, a released wire rises
  always_comb begin
    lvl = ~(pull | dev_oe);
    if (link_low) begin
      lvl[hsb_pkg::IN_BP_CLK] = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== test/hsb_bus_buffer_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module hsb_bus_buffer_tb_top;
  localparam int IDLE = 20; // short idle interval keeps the run brief
  logic clk_sys, srst, supply_good, connect_inhibit, frame_on;
  logic [3:0] pull; // bench drivers, indexed like the design's input vector
  logic [3:0] dev_oe; // device pull-downs in the same order
  logic [3:0] lvl; // resolved wire levels
  logic ready_oe, precharge_en;
  logic [3:0] dev_out; // device drive values on the four wires, open drain so always low
  logic ready_pin; // device drive value on the ready pin
  int n_mismatch, n_compared, cycles;
  ////////////////////////////////////////
  hsb_bus_buffer #(.IDLE_CYCLES(IDLE)) hsb_bus_buffer_inst (
    .clk_sys(clk_sys), .srst(srst), .supply_good(supply_good), .connect_inhibit(connect_inhibit),
    .backplane_data_line_in(lvl[0]), .backplane_data_line_out(dev_out[0]), .backplane_data_line_oe(dev_oe[0]),
    .backplane_clock_line_in(lvl[1]), .backplane_clock_line_out(dev_out[1]),
    .backplane_clock_line_oe(dev_oe[1]),
    .card_data_line_in(lvl[2]), .card_data_line_out(dev_out[2]), .card_data_line_oe(dev_oe[2]),
    .card_clock_line_in(lvl[3]), .card_clock_line_out(dev_out[3]), .card_clock_line_oe(dev_oe[3]),
    .ready_out(ready_pin), .ready_oe(ready_oe), .precharge_en(precharge_en));
  hsb_bus_partner hsb_bus_partner_inst (.frame_on(frame_on), .pull(pull), .dev_oe(dev_oe), .lvl(lvl));
  ////////////////////////////////////////
  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input string what, input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // bounded wait for the ready pull-down to reach v, then judge it
  task automatic wait_rdy(input logic v, input int n);
    for (int i = 0; i < n && ready_oe !== v; i++) @(negedge clk_sys);
    chk("ready_oe", ready_oe, v);
  endtask
  task automatic end_of_test;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // supply low: bus activity and a long idle must change nothing
  task automatic t_lockout;
    pull[0] = 1'b1;
    cyc(5);
    chk("oe in lockout", dev_oe == 4'h0, 1'b1);
    pull[0] = 1'b0;
    cyc(IDLE + 10);
    chk("ready_oe", ready_oe, 1'b1);
    chk("precharge_en", precharge_en, 1'b1);
  endtask
  // idle already seen, but a low card data line must hold off the join
  task automatic t_connect;
    pull[2] = 1'b1;
    supply_good = 1'b1;
    cyc(30);
    chk("precharge_en", precharge_en, 1'b0);
    chk("ready_oe", ready_oe, 1'b1);
    chk("oe before join", dev_oe == 4'h0, 1'b1);
    // a backplane clock low during the card check voids the idle already seen
    pull[1] = 1'b1;
    cyc(4);
    pull[1] = 1'b0;
    pull[2] = 1'b0;
    cyc(10);
    chk("ready_oe", ready_oe, 1'b1);
    wait_rdy(1'b0, 20);
  endtask
  // a low on one side shows on the other, and clears when released
  task automatic follow(input int k);
    pull[k] = 1'b1;
    cyc(4);
    chk("far oe", dev_oe[k ^ 2], 1'b1);
    chk("far wire", lvl[k ^ 2], 1'b0);
    pull[k] = 1'b0;
    cyc(4);
    chk("far oe", dev_oe[k ^ 2], 1'b0);
    chk("far wire", lvl[k ^ 2], 1'b1);
    cyc(8);
  endtask
  task automatic t_pairs;
    for (int k = 0; k < 4; k++) follow(k);
    chk("line out", dev_out == 4'h0, 1'b1);
  endtask
  // a clocked frame on the backplane reaches the card clock wire
  task automatic t_frame;
    int lows;
    lows = 0;
    frame_on = 1'b1;
    for (int i = 0; i < 40; i++) begin
      cyc(1);
      if (lvl[3] === 1'b0) lows++;
    end
    chk("card clock followed", lows > 0, 1'b1);
    chk("ready_oe", ready_oe, 1'b0);
    frame_on = 1'b0;
    cyc(20);
    chk("card clock idle", lvl[3], 1'b1);
  endtask
  // inhibit cuts the join; rejoin only after a stop on the backplane
  task automatic t_inhibit;
    connect_inhibit = 1'b1;
    cyc(4);
    chk("ready_oe", ready_oe, 1'b1);
    chk("ready pin", ready_oe ? ready_pin : 1'b1, 1'b0);
    pull[0] = 1'b1;
    cyc(4);
    chk("oe under inhibit", dev_oe == 4'h0, 1'b1);
    connect_inhibit = 1'b0;
    cyc(30);
    chk("ready_oe", ready_oe, 1'b1);
    pull[0] = 1'b0;
    wait_rdy(1'b0, 8);
  endtask
  // supply loss returns to lockout; rejoin then needs a full idle
  task automatic t_supply;
    pull[1] = 1'b1;
    supply_good = 1'b0;
    cyc(4);
    chk("ready_oe", ready_oe, 1'b1);
    chk("precharge_en", precharge_en, 1'b1);
    chk("oe in lockout", dev_oe == 4'h0, 1'b1);
    supply_good = 1'b1;
    cyc(6);
    pull[1] = 1'b0;
    cyc(10);
    chk("ready_oe", ready_oe, 1'b1);
    wait_rdy(1'b0, 20);
  endtask
  ////////////////////////////////////////
  initial begin
    srst = 1'b1;
    supply_good = 1'b0;
    connect_inhibit = 1'b0;
    frame_on = 1'b0;
    pull = 4'h0;
    cyc(10);
    srst = 1'b0;
    t_lockout();
    t_connect();
    t_pairs();
    t_frame();
    t_inhibit();
    t_supply();
    end_of_test();
  end
endmodule
`default_nettype wire
